// [verilog/rbt_transceiver.sv]
// Purpose: Registered bidirectional bus transceiver, normal-mode datapath, per section
// Assumes: All bus and control pins are asynchronous to CLK and pass two flip-flops before use; APB inputs are used directly
// Notes: Pin-to-pin latency is three CLK cycles; capture clocks must stay high and low
// Notes: for at least two CLK periods each so that every rising edge is seen
//
// Behaviour
// - Outputs enabled with direction high drive the B bus from the A side, A is input.
// - Outputs enabled with direction low drive the A bus from the B side, B is input.
// - Output enable high releases both buses, isolating them from each other.
// - Each rising edge of the A-to-B capture clock stores the A bus value.
// - With the A-to-B source select low, B carries the live A value.
// - With the A-to-B source select high, B carries the stored A value.
// - The B-to-A capture clock and select mirror the A-to-B ones for the A bus.
// - Enabled, direction low and B-to-A select low pass the live B value to A.
// - Enabled, direction low and B-to-A select high drive A from the stored B value.
// - Test mode suspends normal drive and releases both buses of every section.
// - Sampling pins through the register port leaves the datapath untouched.
// - Two independent 9-bit sections, usable alone or together as one 18-bit path.
// - Capture happens on every rising edge whatever the enable and direction.
`timescale 1ns/1ps
module rbt_transceiver import rbt_pkg::*; #(
  parameter int SECT_W = RBT_SECT_W,
  parameter int N_SECT = RBT_N_SECT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Section controls, one bit per section
  input wire logic [N_SECT-1:0] OE_N,
  input wire logic [N_SECT-1:0] DIR,
  input wire logic [N_SECT-1:0] A_TO_B_CAPTURE_CLK,
  input wire logic [N_SECT-1:0] B_TO_A_CAPTURE_CLK,
  input wire logic [N_SECT-1:0] A_TO_B_SOURCE_SEL,
  input wire logic [N_SECT-1:0] B_TO_A_SOURCE_SEL,
  // A bus pins
  input wire logic [N_SECT-1:0][SECT_W-1:0] A_IN,
  output logic [N_SECT-1:0][SECT_W-1:0] A_OUT,
  output logic [N_SECT-1:0][SECT_W-1:0] A_OE,
  // B bus pins
  input wire logic [N_SECT-1:0][SECT_W-1:0] B_IN,
  output logic [N_SECT-1:0][SECT_W-1:0] B_OUT,
  output logic [N_SECT-1:0][SECT_W-1:0] B_OE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [RBT_ADDR_W-1:0] PADDR,
  input wire logic [RBT_DATA_W-1:0] PWDATA,
  output logic [RBT_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  function automatic logic [SECT_W-1:0] pick(input logic sel, input logic [SECT_W-1:0] stored,
                                             input logic [SECT_W-1:0] live);
    pick = sel ? stored : live;
  endfunction

  // Synchronisers: stage one feeds stage two only
  rbt_ctl_t [N_SECT-1:0] ctl_s1, ctl_s2;
  logic [N_SECT-1:0] cab_prev, cba_prev;
  logic [N_SECT-1:0][SECT_W-1:0] a_s1, a_s2, b_s1, b_s2;
  logic [N_SECT-1:0] cab_rise, cba_rise;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_s1 <= {N_SECT{RBT_CTL_RST}};
      ctl_s2 <= {N_SECT{RBT_CTL_RST}};
      cab_prev <= '0;
      cba_prev <= '0;
      a_s1 <= '0;
      a_s2 <= '0;
      b_s1 <= '0;
      b_s2 <= '0;
    end else begin
      for (int s = 0; s < N_SECT; s++) begin
        ctl_s1[s] <= '{oe_n: OE_N[s], dir: DIR[s], clk_ab: A_TO_B_CAPTURE_CLK[s],
                       clk_ba: B_TO_A_CAPTURE_CLK[s], sel_ab: A_TO_B_SOURCE_SEL[s],
                       sel_ba: B_TO_A_SOURCE_SEL[s]};
        cab_prev[s] <= ctl_s2[s].clk_ab;
        cba_prev[s] <= ctl_s2[s].clk_ba;
      end
      ctl_s2 <= ctl_s1;
      a_s1 <= A_IN;
      a_s2 <= a_s1;
      b_s1 <= B_IN;
      b_s2 <= b_s1;
    end
  end

  always_comb begin
    for (int s = 0; s < N_SECT; s++) begin
      cab_rise[s] = ctl_s2[s].clk_ab & ~cab_prev[s];
      cba_rise[s] = ctl_s2[s].clk_ba & ~cba_prev[s];
    end
  end

  // Storage and output drive
  logic test_mode, next_test_mode;
  logic [N_SECT-1:0][SECT_W-1:0] store_a, store_b, next_store_a, next_store_b;
  logic [N_SECT-1:0][SECT_W-1:0] next_a_out, next_a_oe, next_b_out, next_b_oe;

  always_comb begin
    next_store_a = store_a;
    next_store_b = store_b;
    next_a_out = A_OUT;
    next_b_out = B_OUT;
    next_a_oe = '0;
    next_b_oe = '0;
    for (int s = 0; s < N_SECT; s++) begin
      // Capture ignores enable and direction
      if (cab_rise[s]) begin
        next_store_a[s] = a_s2[s];
      end
      if (cba_rise[s]) begin
        next_store_b[s] = b_s2[s];
      end
      // Test mode owns the pins, so normal drive is withheld
      if (!ctl_s2[s].oe_n && !test_mode) begin
        if (ctl_s2[s].dir) begin
          next_b_oe[s] = {SECT_W{1'b1}};
          next_b_out[s] = pick(ctl_s2[s].sel_ab, store_a[s], a_s2[s]);
        end else begin
          next_a_oe[s] = {SECT_W{1'b1}};
          next_a_out[s] = pick(ctl_s2[s].sel_ba, store_b[s], b_s2[s]);
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      store_a <= '0;
      store_b <= '0;
      A_OUT <= '0;
      B_OUT <= '0;
      A_OE <= '0;
      B_OE <= '0;
    end else begin
      store_a <= next_store_a;
      store_b <= next_store_b;
      A_OUT <= next_a_out;
      B_OUT <= next_b_out;
      A_OE <= next_a_oe;
      B_OE <= next_b_oe;
    end
  end

  // APB slave; answer in the second cycle of the access phase so PRDATA comes from a flop
  logic access;
  logic [RBT_DATA_W-1:0] next_prdata;
  logic next_pready, next_pslverr;

  assign access = PSEL & PENABLE & ~PREADY;

  always_comb begin
    next_test_mode = test_mode;
    next_prdata = RBT_ZERO_WORD;
    next_pready = access;
    next_pslverr = 1'b0;
    if (access) begin
      case (PADDR)
        RBT_CTRL_OFS: begin
          if (PWRITE) begin
            next_test_mode = PWDATA[RBT_CTRL_TEST_BIT];
          end else begin
            next_prdata[RBT_CTRL_TEST_BIT] = test_mode;
          end
        end
        RBT_STORE_A_OFS: next_prdata = RBT_DATA_W'(store_a);
        RBT_STORE_B_OFS: next_prdata = RBT_DATA_W'(store_b);
        // Pin snapshots are read-only views; reading them touches no datapath state
        RBT_PINS_A_OFS: next_prdata = RBT_DATA_W'(a_s2);
        RBT_PINS_B_OFS: next_prdata = RBT_DATA_W'(b_s2);
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      test_mode <= RBT_TEST_RST;
      PRDATA <= RBT_ZERO_WORD;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      test_mode <= next_test_mode;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // Checks per section
  for (genvar g = 0; g < N_SECT; g++) begin : g_chk
    chk_b_drive_dir: assert property (@(posedge CLK) disable iff (RST)
      (B_OE[g] != '0) == $past(!ctl_s2[g].oe_n && ctl_s2[g].dir && !test_mode))
      else $error("B drive does not follow enable and direction");

    chk_a_drive_dir: assert property (@(posedge CLK) disable iff (RST)
      (A_OE[g] != '0) == $past(!ctl_s2[g].oe_n && !ctl_s2[g].dir && !test_mode))
      else $error("A drive does not follow enable and direction");

    chk_isolate_both: assert property (@(posedge CLK) disable iff (RST)
      ctl_s2[g].oe_n |=> (A_OE[g] == '0) && (B_OE[g] == '0))
      else $error("Bus driven while output enable is high");

    chk_capture_a: assert property (@(posedge CLK) disable iff (RST)
      cab_rise[g] |=> store_a[g] == $past(a_s2[g]))
      else $error("A storage missed a capture");

    chk_b_live: assert property (@(posedge CLK) disable iff (RST)
      (B_OE[g] != '0) && !$past(ctl_s2[g].sel_ab) |-> B_OUT[g] == $past(a_s2[g]))
      else $error("B bus not carrying live A data");

    chk_b_stored: assert property (@(posedge CLK) disable iff (RST)
      (B_OE[g] != '0) && $past(ctl_s2[g].sel_ab) |-> B_OUT[g] == $past(store_a[g]))
      else $error("B bus not carrying stored A data");

    chk_capture_b: assert property (@(posedge CLK) disable iff (RST)
      cba_rise[g] |=> store_b[g] == $past(b_s2[g]))
      else $error("B storage missed a capture");

    chk_a_live: assert property (@(posedge CLK) disable iff (RST)
      (A_OE[g] != '0) && !$past(ctl_s2[g].sel_ba) |-> A_OUT[g] == $past(b_s2[g]))
      else $error("A bus not carrying live B data");

    chk_a_stored: assert property (@(posedge CLK) disable iff (RST)
      (A_OE[g] != '0) && $past(ctl_s2[g].sel_ba) |-> A_OUT[g] == $past(store_b[g]))
      else $error("A bus not carrying stored B data");

    chk_test_release: assert property (@(posedge CLK) disable iff (RST)
      test_mode |=> (A_OE[g] == '0) && (B_OE[g] == '0))
      else $error("Pins driven in test mode");

    chk_hold_store: assert property (@(posedge CLK) disable iff (RST)
      !cab_rise[g] && !cba_rise[g] |=> $stable(store_a[g]) && $stable(store_b[g]))
      else $error("Storage changed without a capture edge");

    chk_capture_gated: assert property (@(posedge CLK) disable iff (RST)
      cab_rise[g] && ctl_s2[g].oe_n ##1 1'b1 |-> store_a[g] == $past(a_s2[g]))
      else $error("Capture lost while outputs disabled");

    // A section never fights itself, and drives all of its bits or none
    chk_one_side: assert property (@(posedge CLK) disable iff (RST)
      !((A_OE[g] != '0) && (B_OE[g] != '0)))
      else $error("Both buses driven by one section");

    chk_oe_uniform: assert property (@(posedge CLK) disable iff (RST)
      ((A_OE[g] == '0) || (A_OE[g] == {SECT_W{1'b1}})) &&
      ((B_OE[g] == '0) || (B_OE[g] == {SECT_W{1'b1}})))
      else $error("Section drive enables differ across bits");

    // Test mode withholds drive only; storage keeps capturing
    chk_test_capture: assert property (@(posedge CLK) disable iff (RST)
      cab_rise[g] && test_mode |=> store_a[g] == $past(a_s2[g]))
      else $error("Capture lost in test mode");

    cov_b_stored: cover property (@(posedge CLK) disable iff (RST)
      (B_OE[g] != '0) && $past(ctl_s2[g].sel_ab));

    cov_a_live: cover property (@(posedge CLK) disable iff (RST)
      (A_OE[g] != '0) && !$past(ctl_s2[g].sel_ba));

    cov_both_capture: cover property (@(posedge CLK) disable iff (RST)
      cab_rise[g] && cba_rise[g]);
  end

  // Register port checks
  chk_ready_answer: assert property (@(posedge CLK) disable iff (RST)
    access |=> PREADY)
    else $error("Register access not answered");

  chk_ready_pulse: assert property (@(posedge CLK) disable iff (RST)
    PREADY |=> !PREADY)
    else $error("Ready held longer than one cycle");

  chk_err_zero: assert property (@(posedge CLK) disable iff (RST)
    PSLVERR |-> PREADY && (PRDATA == RBT_ZERO_WORD))
    else $error("Error answer carries data");

  chk_mode_write: assert property (@(posedge CLK) disable iff (RST)
    access && PWRITE && (PADDR == RBT_CTRL_OFS) |=>
      test_mode == $past(PWDATA[RBT_CTRL_TEST_BIT]))
    else $error("Test mode write not taken");

  chk_mode_hold: assert property (@(posedge CLK) disable iff (RST)
    !(access && PWRITE && (PADDR == RBT_CTRL_OFS)) |=> $stable(test_mode))
    else $error("Test mode changed without a write");

  chk_store_view: assert property (@(posedge CLK) disable iff (RST)
    access && !PWRITE && (PADDR == RBT_STORE_A_OFS) |=>
      PRDATA == RBT_DATA_W'($past(store_a)))
    else $error("Stored A read back wrong");

  chk_pins_a_view: assert property (@(posedge CLK) disable iff (RST)
    access && !PWRITE && (PADDR == RBT_PINS_A_OFS) |=> PRDATA == RBT_DATA_W'($past(a_s2)))
    else $error("A pin snapshot read back wrong");

  chk_pins_b_view: assert property (@(posedge CLK) disable iff (RST)
    access && !PWRITE && (PADDR == RBT_PINS_B_OFS) |=> PRDATA == RBT_DATA_W'($past(b_s2)))
    else $error("B pin snapshot read back wrong");

  chk_ro_write: assert property (@(posedge CLK) disable iff (RST)
    access && PWRITE && (PADDR == RBT_STORE_A_OFS) && (cab_rise == '0) |=> $stable(store_a))
    else $error("Read-only write changed storage");

  cov_test_mode: cover property (@(posedge CLK) disable iff (RST) $rose(test_mode));
  cov_err_access: cover property (@(posedge CLK) disable iff (RST) PSLVERR);

endmodule

// [verilog/rbt_pkg.sv]
// Purpose: Shared constants and carrier types for the registered bus transceiver
// Assumes: 32-bit APB register access, byte addresses on word boundaries
// Notes: Section count and width defaults give two 9-bit sections
package rbt_pkg;
  localparam int RBT_SECT_W = 9;
  localparam int RBT_N_SECT = 2;
  localparam int RBT_ADDR_W = 8;
  localparam int RBT_DATA_W = 32;
  // Register byte offsets
  localparam logic [RBT_ADDR_W-1:0] RBT_CTRL_OFS = 8'h00;
  localparam logic [RBT_ADDR_W-1:0] RBT_STORE_A_OFS = 8'h04;
  localparam logic [RBT_ADDR_W-1:0] RBT_STORE_B_OFS = 8'h08;
  localparam logic [RBT_ADDR_W-1:0] RBT_PINS_A_OFS = 8'h0C;
  localparam logic [RBT_ADDR_W-1:0] RBT_PINS_B_OFS = 8'h10;
  // Control register layout and reset value
  localparam int RBT_CTRL_TEST_BIT = 0;
  localparam logic RBT_TEST_RST = 1'b0;
  localparam logic [RBT_DATA_W-1:0] RBT_ZERO_WORD = 32'h0000_0000;

  // One section's control pins, carried together through the synchroniser
  typedef struct packed {
    logic oe_n;
    logic dir;
    logic clk_ab;
    logic clk_ba;
    logic sel_ab;
    logic sel_ba;
  } rbt_ctl_t;

  localparam rbt_ctl_t RBT_CTL_RST = '{oe_n: 1'b1, dir: 1'b0, clk_ab: 1'b0,
                                       clk_ba: 1'b0, sel_ab: 1'b0, sel_ba: 1'b0};
endpackage

// [tb/rbt_board_model.sv]
// Purpose: Board logic on one parallel bus, resolving each shared wire
// Assumes: The bench lets the board drive only while the device has released the wire
// Notes: An undriven wire shows the inverse of its last level, so stale data never passes
`timescale 1ns/1ps
module rbt_board_model #(
  parameter int N = 2,
  parameter int W = 9
) (
  // Clock
  input wire logic clk,
  // Board side, one enable per section
  input wire logic [N-1:0] brd_en,
  input wire logic [N-1:0][W-1:0] brd_val,
  // Device side
  input wire logic [N-1:0][W-1:0] dev_oe,
  input wire logic [N-1:0][W-1:0] dev_out,
  // Resolved wire level
  output logic [N-1:0][W-1:0] wire_lvl
);
  logic [N-1:0][W-1:0] last = '0;
  always @(posedge clk) begin
    last <= wire_lvl;
  end
  always_comb begin
    for (int s = 0; s < N; s++) begin
      for (int i = 0; i < W; i++) begin
        if (dev_oe[s][i])
          wire_lvl[s][i] = dev_out[s][i];
        else if (brd_en[s])
          wire_lvl[s][i] = brd_val[s][i];
        else
          wire_lvl[s][i] = ~last[s][i];
      end
    end
  end
endmodule

// [tb/registered_bus_transceiver_9bit_tb.sv]
// Purpose: Random and corner checks of the registered bus transceiver
// Assumes: Board models resolve both buses; the bench is the APB master
// Notes: Captures only from a bus the device is not driving, else the value is undefined
`timescale 1ns/1ps
module registered_bus_transceiver_9bit_tb import rbt_pkg::*;;
  localparam int W = RBT_SECT_W;
  localparam int N = RBT_N_SECT;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [N-1:0] oe_n = '1, dir = '0, cab = '0, cba = '0, sel_ab = '0, sel_ba = '0;
  logic [N-1:0] brd_a_en = '1, brd_b_en = '1;
  logic [N-1:0][W-1:0] brd_a = '0, brd_b = '0, exp_sa = '0, exp_sb = '0;
  logic [N-1:0][W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [RBT_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  int err_total = 0;
  int n_compared = 0;
  initial forever #20 CLK = ~CLK;
  rbt_transceiver i_dut (.CLK(CLK), .RST(RST), .OE_N(oe_n), .DIR(dir),
    .A_TO_B_CAPTURE_CLK(cab), .B_TO_A_CAPTURE_CLK(cba), .A_TO_B_SOURCE_SEL(sel_ab),
    .B_TO_A_SOURCE_SEL(sel_ba), .A_IN(a_in), .A_OUT(a_out), .A_OE(a_oe), .B_IN(b_in),
    .B_OUT(b_out), .B_OE(b_oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  rbt_board_model #(.N(N), .W(W)) i_bus_a (.clk(CLK), .brd_en(brd_a_en), .brd_val(brd_a),
    .dev_oe(a_oe), .dev_out(a_out), .wire_lvl(a_in));
  rbt_board_model #(.N(N), .W(W)) i_bus_b (.clk(CLK), .brd_en(brd_b_en), .brd_val(brd_b),
    .dev_oe(b_oe), .dev_out(b_out), .wire_lvl(b_in));
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [W-1:0] pick(logic sel, logic [W-1:0] st, logic [W-1:0] live);
    return sel ? st : live;
  endfunction
  // Level on a wire: the device's drive where it drives, else the board's value
  function automatic logic [W-1:0] exp_wire(logic drv, logic sel, logic [W-1:0] st,
                                            logic [W-1:0] far, logic [W-1:0] brd);
    return drv ? pick(sel, st, far) : brd;
  endfunction
  task automatic apb(input logic wr, input logic [RBT_ADDR_W-1:0] adr, input logic [31:0] wd);
    int i;
    @(posedge CLK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge CLK);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_pins(input logic tmode);
    logic en;
    for (int s = 0; s < N; s++) begin
      en = ~oe_n[s] & ~tmode;
      chk("B_OE", 32'({W{en & dir[s]}}), 32'(b_oe[s]));
      chk("A_OE", 32'({W{en & ~dir[s]}}), 32'(a_oe[s]));
      if (en & dir[s])
        chk("B_OUT", 32'(pick(sel_ab[s], exp_sa[s], brd_a[s])), 32'(b_out[s]));
      if (en & ~dir[s])
        chk("A_OUT", 32'(pick(sel_ba[s], exp_sb[s], brd_b[s])), 32'(a_out[s]));
    end
  endtask
  initial begin
    logic [N-1:0] o, d, ca, cb;
    logic [W-1:0] ew;
    void'($urandom(32'h9EEB));
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    chk_pins(1'b0);
    apb(1'b0, RBT_CTRL_OFS, '0);
    chk("CTRL", 32'h0, rd);
    for (int it = 0; it < 48; it++) begin
      o = N'($urandom);
      d = N'($urandom);
      ca = N'($urandom) & (o | d);
      cb = N'($urandom) & (o | ~d);
      oe_n <= o;
      dir <= d;
      sel_ab <= N'($urandom);
      sel_ba <= N'($urandom);
      brd_a_en <= o | d;
      brd_b_en <= o | ~d;
      brd_a <= (N*W)'($urandom);
      brd_b <= (N*W)'($urandom);
      repeat (4) @(posedge CLK);
      cab <= ca;
      cba <= cb;
      repeat (3) @(posedge CLK);
      cab <= '0;
      cba <= '0;
      for (int s = 0; s < N; s++) begin
        if (ca[s]) exp_sa[s] = brd_a[s];
        if (cb[s]) exp_sb[s] = brd_b[s];
      end
      repeat (6) @(posedge CLK);
      chk_pins(1'b0);
      apb(1'b0, RBT_STORE_A_OFS, '0);
      chk("STORE_A", 32'(exp_sa), rd);
      apb(1'b0, RBT_STORE_B_OFS, '0);
      chk("STORE_B", 32'(exp_sb), rd);
      apb(1'b0, RBT_PINS_A_OFS, '0);
      for (int s = 0; s < N; s++) begin
        ew = exp_wire(~o[s] & ~d[s], sel_ba[s], exp_sb[s], brd_b[s], brd_a[s]);
        chk("PINS_A", 32'(ew), 32'(rd[s*W +: W]));
      end
      apb(1'b0, RBT_PINS_B_OFS, '0);
      for (int s = 0; s < N; s++) begin
        ew = exp_wire(~o[s] & d[s], sel_ab[s], exp_sa[s], brd_a[s], brd_b[s]);
        chk("PINS_B", 32'(ew), 32'(rd[s*W +: W]));
      end
      chk_pins(1'b0);
    end
    // Corner: test mode releases every pin, then refused and read-only accesses
    oe_n <= '0;
    dir <= N'(1);
    brd_a_en <= N'(1);
    brd_b_en <= ~N'(1);
    apb(1'b1, RBT_CTRL_OFS, 32'h1);
    repeat (4) @(posedge CLK);
    chk_pins(1'b1);
    // Capture on section 0 while test mode holds the pins released
    brd_a <= (N*W)'($urandom);
    repeat (2) @(posedge CLK);
    cab <= N'(1);
    repeat (3) @(posedge CLK);
    cab <= '0;
    exp_sa[0] = brd_a[0];
    apb(1'b0, RBT_CTRL_OFS, '0);
    chk("CTRL", 32'h1, rd);
    apb(1'b1, RBT_STORE_A_OFS, 32'h3FFFF);
    apb(1'b0, 8'h14, '0);
    chk("PSLVERR", 32'h1, 32'(err));
    chk("PRDATA", 32'h0, rd);
    apb(1'b0, RBT_STORE_A_OFS, '0);
    chk("STORE_A", 32'(exp_sa), rd);
    apb(1'b1, RBT_CTRL_OFS, 32'h0);
    repeat (4) @(posedge CLK);
    chk_pins(1'b0);
    wrap_up();
  end
endmodule
